// File: core/sak_defs.vh
// constants shared by the interpolation and kill slice
// assumes 32-bit single float operands and an 11-bit opcode field
`ifndef SAK_DEFS_VH
`define SAK_DEFS_VH
`define SAK_OP_W 11
`define SAK_OP_INTERP_PAIR_XY 11'h0d6
`define SAK_OP_INTERP_PAIR_ZW 11'h0d7
`define SAK_OP_INTERP_SINGLE_Z 11'h0d9
`define SAK_OP_FKILL_EQ 11'h02c
`define SAK_OP_FKILL_GT 11'h02d
`define SAK_OP_FKILL_GE 11'h02e
`define SAK_OP_FKILL_NE 11'h02f
`define SAK_OP_UKILL_GT 11'h040
`define SAK_OP_UKILL_GE 11'h041
`define SAK_OP_SKILL_EQ 11'h046
`define SAK_OP_SKILL_GT 11'h047
`define SAK_OP_IKILL_GE 11'h048
`define SAK_F_ONE 32'h3f800000
`define SAK_F_ZERO 32'h00000000
`define SAK_F_INF_EXP 8'hff
`define SAK_EXP_BIAS 11'h07f
`define SAK_EXP_MAX 11'h0ff
`define SAK_EXT_W 60
`define SAK_EXT_SIGN 59
`define SAK_EXT_EXP_HI 58
`define SAK_EXT_EXP_LO 48
`define SAK_MANT_W 48
`define SAK_ALIGN_MAX 11'h031
`define SAK_LANES 4
`define SAK_CH_X 0
`define SAK_CH_Y 1
`define SAK_CH_Z 2
`define SAK_CH_W 3
`endif

// File: core/sak_mad_unit.v
// one fused multiply-add lane: a*b + c, c held in the unrounded extended form
// assumes normal floats; denormals flush to zero, nan/inf inputs are not special-cased
`timescale 1ns/10ps
`include "sak_defs.vh"
module sak_mad_unit (
  input wire [31:0] mul_a_i,
  input wire [31:0] mul_b_i,
  input wire [`SAK_EXT_W-1:0] add_ext_i,
  output reg [`SAK_EXT_W-1:0] sum_ext_o,
  output reg [31:0] sum_rnd_o
);
  reg [47:0] prod;
  reg [47:0] pm;
  reg [10:0] pe;
  reg ps;
  reg pz;
  reg [47:0] ym;
  reg [10:0] ye;
  reg ys;
  reg x_big;
  reg [47:0] bm;
  reg [47:0] sm;
  reg [10:0] be;
  reg bs;
  reg ss;
  reg [10:0] diff;
  reg [48:0] s;
  reg [47:0] m;
  reg [10:0] e;
  reg rs;
  reg [24:0] r;
  reg [10:0] er;
  integer k;
  always @* begin
    prod = {1'b1, mul_a_i[22:0]} * {1'b1, mul_b_i[22:0]};
    ps = mul_a_i[31] ^ mul_b_i[31];
    pz = (mul_a_i[30:23] == 8'h00) || (mul_b_i[30:23] == 8'h00);
    pe = {3'b000, mul_a_i[30:23]} + {3'b000, mul_b_i[30:23]} - `SAK_EXP_BIAS
         + {10'h000, prod[47]};
    pm = prod[47] ? prod : {prod[46:0], 1'b0};
    if (pz) begin
      pm = 48'h0;
    end
    ym = add_ext_i[`SAK_MANT_W-1:0];
    ye = add_ext_i[`SAK_EXT_EXP_HI:`SAK_EXT_EXP_LO];
    ys = add_ext_i[`SAK_EXT_SIGN];
    // a zero operand must lose the alignment race whatever its exponent
    diff = pe - ye;
    x_big = (ym == 48'h0) || ((pm != 48'h0) && !diff[10]);
    bm = x_big ? pm : ym;
    be = x_big ? pe : ye;
    bs = x_big ? ps : ys;
    sm = x_big ? ym : pm;
    ss = x_big ? ys : ps;
    diff = x_big ? (pe - ye) : (ye - pe);
    sm = (diff > `SAK_ALIGN_MAX) ? 48'h0 : (sm >> diff);
    rs = bs;
    if (bs == ss) begin
      s = {1'b0, bm} + {1'b0, sm};
    end else if (bm >= sm) begin
      s = {1'b0, bm} - {1'b0, sm};
    end else begin
      s = {1'b0, sm} - {1'b0, bm};
      rs = ss;
    end
    e = be;
    m = s[47:0];
    if (s[48]) begin
      m = s[48:1];
      e = be + 11'h001;
    end
    for (k = 0; k < `SAK_MANT_W; k = k + 1) begin
      if (!m[47] && (m != 48'h0)) begin
        m = {m[46:0], 1'b0};
        e = e - 11'h001;
      end
    end
    // the extended sum keeps all 48 bits: no rounding before the dot-path add
    if ((m == 48'h0) || e[10] || (e == 11'h000)) begin
      sum_ext_o = {`SAK_EXT_W{1'b0}};
    end else begin
      sum_ext_o = {rs, e, m};
    end
    r = {1'b0, m[47:24]} + {24'h000000, m[23]};
    er = e + {10'h000, r[24]};
    if ((m == 48'h0) || er[10] || (er == 11'h000)) begin
      sum_rnd_o = `SAK_F_ZERO;
    end else if (er >= `SAK_EXP_MAX) begin
      sum_rnd_o = {rs, `SAK_F_INF_EXP, 23'h000000};
    end else begin
      sum_rnd_o = {rs, er[7:0], r[24] ? 23'h000000 : r[22:0]};
    end
  end
endmodule

// File: core/sak_kill_cmp.v
// condition decode for the conditional pixel-kill family of one channel
// assumes raw 32-bit operands; float nan compares unordered
`timescale 1ns/10ps
`include "sak_defs.vh"
module sak_kill_cmp #(
  parameter INT_GE_SIGNED = 0
) (
  input wire [`SAK_OP_W-1:0] opcode_i,
  input wire [31:0] src0_i,
  input wire [31:0] src1_i,
  output reg is_kill_o,
  output reg hit_o
);
  wire nan0 = (src0_i[30:23] == `SAK_F_INF_EXP) && (src0_i[22:0] != 23'h0);
  wire nan1 = (src1_i[30:23] == `SAK_F_INF_EXP) && (src1_i[22:0] != 23'h0);
  wire unord = nan0 | nan1;
  // +0 and -0 are equal as floats though their bits differ
  wire f_eq = !unord && ((src0_i == src1_i) || ((src0_i[30:0] | src1_i[30:0]) == 31'h0));
  wire mag_gt = src0_i[30:0] > src1_i[30:0];
  wire mag_lt = src0_i[30:0] < src1_i[30:0];
  wire f_gt = !unord && !f_eq && ((!src0_i[31] && src1_i[31]) ||
              (!src0_i[31] && !src1_i[31] && mag_gt) ||
              (src0_i[31] && src1_i[31] && mag_lt));
  wire s_gt = $signed(src0_i) > $signed(src1_i);
  wire u_gt = src0_i > src1_i;
  wire i_eq = src0_i == src1_i;
  always @* begin
    is_kill_o = 1'b1;
    hit_o = 1'b0;
    case (opcode_i)
      `SAK_OP_FKILL_EQ: hit_o = f_eq;
      `SAK_OP_FKILL_GT: hit_o = f_gt;
      `SAK_OP_FKILL_GE: hit_o = f_gt | f_eq;
      `SAK_OP_FKILL_NE: hit_o = !f_eq;
      `SAK_OP_SKILL_EQ: hit_o = i_eq;
      `SAK_OP_SKILL_GT: hit_o = s_gt;
      `SAK_OP_IKILL_GE: hit_o = i_eq | ((INT_GE_SIGNED != 0) ? s_gt : u_gt);
      `SAK_OP_UKILL_GT: hit_o = u_gt;
      `SAK_OP_UKILL_GE: hit_o = u_gt | i_eq;
      default: is_kill_o = 1'b0;
    endcase
  end
endmodule

// File: core/sak_alu_slice.v
// alu execution slice: cross-channel attribute interpolation and pixel-kill compares
// assumes the sequencer presents one decoded four-channel group per cycle,
// with operands already fetched, and marks thread start and clause end
//
// How it works
// - single z: w multiply-adds, z adds w result on dot path.
// - multiply-add result enters dot-path add unrounded, not ieee compliant.
// - pair zw uses all four channels: w,y multiply-add; z,x dot-path add.
// - pair zw routes z result onto y output, x result onto w output.
// - interpolation opcodes: pair xy 214, pair zw 215, single z 217.
// - kill compare writes 1.0 and sets kill when true, else writes 0.0.
// - kill compares act only in pixel programs, ignored elsewhere.
// - clause sees pre-kill valid state; issuer puts kill last in clause.
// - float kill equal 44, greater 45, greater-or-equal 46.
// - float not-equal kill fires when sources differ as floats.
// - signed kill equal 70, greater 71.
// - integer greater-or-equal kill is 72, signedness selectable.
// - unsigned kill greater 64, greater-or-equal 65.
// - float not-equal kill decodes at 47.
// - pair xy: z result routed onto y output, x stays on x.
`timescale 1ns/10ps
`include "sak_defs.vh"
module sak_alu_slice #(
  parameter INT_GE_SIGNED = 0
) (
  input wire CLK_SYS_I,
  input wire RESET_N_I,
  input wire GROUP_VALID_I,
  input wire [4*`SAK_OP_W-1:0] ALU_OPCODE_FIELD_I,
  input wire [127:0] SRC0_I,
  input wire [127:0] SRC1_I,
  input wire [127:0] SRC2_I,
  input wire PIXEL_PROGRAM_I,
  input wire THREAD_START_I,
  input wire CLAUSE_END_I,
  output wire [127:0] RESULT_O,
  output wire [3:0] WRITE_MASK_O,
  output wire RESULT_VALID_O,
  output wire GROUP_ERROR_O,
  output wire PIXEL_KILLED_O,
  output wire PIXEL_LIVE_O
);
  wire [3:0] is_xy;
  wire [3:0] is_zw;
  wire [3:0] is_z;
  wire [3:0] is_kill;
  wire [3:0] kill_hit;
  wire [31:0] lane_rnd [0:3];
  wire [`SAK_EXT_W-1:0] lane_ext [0:3];
  reg [127:0] result_nxt;
  reg [3:0] wmask_nxt;
  reg [127:0] result_r;
  reg [3:0] wmask_r;
  reg valid_r;
  reg err_r;
  reg killed_r;
  reg live_r;

  genvar c;
  generate
    for (c = 0; c < `SAK_LANES; c = c + 1) begin : g_ch
      wire [`SAK_OP_W-1:0] op = ALU_OPCODE_FIELD_I[c*`SAK_OP_W +: `SAK_OP_W];
      assign is_xy[c] = op == `SAK_OP_INTERP_PAIR_XY;
      assign is_zw[c] = op == `SAK_OP_INTERP_PAIR_ZW;
      assign is_z[c] = op == `SAK_OP_INTERP_SINGLE_Z;
      sak_kill_cmp #(
        .INT_GE_SIGNED(INT_GE_SIGNED)
      ) u_kill (
        .opcode_i(op),
        .src0_i(SRC0_I[c*32 +: 32]),
        .src1_i(SRC1_I[c*32 +: 32]),
        .is_kill_o(is_kill[c]),
        .hit_o(kill_hit[c])
      );
    end
    // pair 0 is y feeding x, pair 1 is w feeding z
    for (c = 0; c < 2; c = c + 1) begin : g_pair
      wire [31:0] p0 = SRC2_I[(2*c+1)*32 +: 32];
      wire p0_zero = p0[30:23] == 8'h00;
      wire [`SAK_EXT_W-1:0] p0_ext = p0_zero ? {`SAK_EXT_W{1'b0}} :
                                     {p0[31], 3'b000, p0[30:23], 1'b1, p0[22:0], 24'h000000};
      sak_mad_unit u_mad (
        .mul_a_i(SRC0_I[(2*c+1)*32 +: 32]),
        .mul_b_i(SRC1_I[(2*c+1)*32 +: 32]),
        .add_ext_i(p0_ext),
        .sum_ext_o(lane_ext[2*c+1]),
        .sum_rnd_o(lane_rnd[2*c+1])
      );
      sak_mad_unit u_dot (
        .mul_a_i(SRC0_I[(2*c)*32 +: 32]),
        .mul_b_i(SRC1_I[(2*c)*32 +: 32]),
        .add_ext_i(lane_ext[2*c+1]),
        .sum_ext_o(lane_ext[2*c]),
        .sum_rnd_o(lane_rnd[2*c])
      );
    end
  endgenerate

  wire all_xy = &is_xy;
  wire all_zw = &is_zw;
  // single z only in w and z together
  wire z_ok = is_z[`SAK_CH_W] & is_z[`SAK_CH_Z] & !is_z[`SAK_CH_X] & !is_z[`SAK_CH_Y];
  wire xy_bad = (|is_xy) & !all_xy;
  wire zw_bad = (|is_zw) & !all_zw;
  wire z_bad = (|is_z) & !z_ok;
  wire group_err = GROUP_VALID_I & (xy_bad | zw_bad | z_bad);
  // kills only take effect in pixel programs
  wire kill_en = GROUP_VALID_I & PIXEL_PROGRAM_I;
  wire kill_fire = kill_en & |(is_kill & kill_hit);

  always @* begin
    result_nxt = 128'h0;
    wmask_nxt = 4'h0;
    if (GROUP_VALID_I) begin
      if (all_xy) begin
        result_nxt[`SAK_CH_X*32 +: 32] = lane_rnd[`SAK_CH_X];
        result_nxt[`SAK_CH_Y*32 +: 32] = lane_rnd[`SAK_CH_Z];
        result_nxt[`SAK_CH_Z*32 +: 32] = lane_rnd[`SAK_CH_Z];
        result_nxt[`SAK_CH_W*32 +: 32] = lane_rnd[`SAK_CH_W];
        wmask_nxt = 4'hf;
      end else if (all_zw) begin
        result_nxt[`SAK_CH_X*32 +: 32] = lane_rnd[`SAK_CH_X];
        result_nxt[`SAK_CH_Y*32 +: 32] = lane_rnd[`SAK_CH_Z];
        result_nxt[`SAK_CH_Z*32 +: 32] = lane_rnd[`SAK_CH_Z];
        result_nxt[`SAK_CH_W*32 +: 32] = lane_rnd[`SAK_CH_X];
        wmask_nxt = 4'hf;
      end else if (z_ok) begin
        result_nxt[`SAK_CH_Z*32 +: 32] = lane_rnd[`SAK_CH_Z];
        result_nxt[`SAK_CH_W*32 +: 32] = lane_rnd[`SAK_CH_W];
        wmask_nxt[`SAK_CH_Z] = 1'b1;
        wmask_nxt[`SAK_CH_W] = 1'b1;
      end
      // kill compares write 1.0 or 0.0
      if (kill_en) begin
        wmask_nxt = wmask_nxt | is_kill;
        result_nxt[`SAK_CH_X*32 +: 32] = is_kill[`SAK_CH_X] ?
          (kill_hit[`SAK_CH_X] ? `SAK_F_ONE : `SAK_F_ZERO) : result_nxt[`SAK_CH_X*32 +: 32];
        result_nxt[`SAK_CH_Y*32 +: 32] = is_kill[`SAK_CH_Y] ?
          (kill_hit[`SAK_CH_Y] ? `SAK_F_ONE : `SAK_F_ZERO) : result_nxt[`SAK_CH_Y*32 +: 32];
        result_nxt[`SAK_CH_Z*32 +: 32] = is_kill[`SAK_CH_Z] ?
          (kill_hit[`SAK_CH_Z] ? `SAK_F_ONE : `SAK_F_ZERO) : result_nxt[`SAK_CH_Z*32 +: 32];
        result_nxt[`SAK_CH_W*32 +: 32] = is_kill[`SAK_CH_W] ?
          (kill_hit[`SAK_CH_W] ? `SAK_F_ONE : `SAK_F_ZERO) : result_nxt[`SAK_CH_W*32 +: 32];
      end
      // a malformed interpolation group writes nothing rather than half a result
      if (xy_bad | zw_bad | z_bad) begin
        wmask_nxt = 4'h0;
      end
    end
  end

  always @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      result_r <= 128'h0;
      wmask_r <= 4'h0;
      valid_r <= 1'b0;
      err_r <= 1'b0;
    end else begin
      result_r <= result_nxt;
      wmask_r <= wmask_nxt;
      valid_r <= GROUP_VALID_I;
      err_r <= group_err;
    end
  end

  always @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      killed_r <= 1'b0;
      live_r <= 1'b1;
    end else begin
      // sticky per thread, a kill in the start cycle belongs to the new thread
      if (kill_fire) begin
        killed_r <= 1'b1;
      end else if (THREAD_START_I) begin
        killed_r <= 1'b0;
      end
      // valid view only moves at clause end or thread start
      if (THREAD_START_I) begin
        live_r <= 1'b1;
      end else if (CLAUSE_END_I) begin
        live_r <= !(killed_r | kill_fire);
      end
    end
  end

  assign RESULT_O = result_r;
  assign WRITE_MASK_O = wmask_r;
  assign RESULT_VALID_O = valid_r;
  assign GROUP_ERROR_O = err_r;
  assign PIXEL_KILLED_O = killed_r;
  assign PIXEL_LIVE_O = live_r;
endmodule

// File: sim/sak_alu_slice_asserts.sv
// port assertions for the alu slice
// assumes one core clock and the active-low async reset
`timescale 1ns/10ps
`include "sak_defs.vh"
module sak_alu_slice_asserts (
  input wire CLK_SYS_I,
  input wire RESET_N_I,
  input wire GROUP_VALID_I,
  input wire [43:0] ALU_OPCODE_FIELD_I,
  input wire [127:0] SRC0_I,
  input wire [127:0] SRC1_I,
  input wire [127:0] SRC2_I,
  input wire PIXEL_PROGRAM_I,
  input wire THREAD_START_I,
  input wire CLAUSE_END_I,
  input wire [127:0] RESULT_O,
  input wire [3:0] WRITE_MASK_O,
  input wire RESULT_VALID_O,
  input wire GROUP_ERROR_O,
  input wire PIXEL_KILLED_O,
  input wire PIXEL_LIVE_O
);
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!RESET_N_I);
  wire [10:0] op_x = ALU_OPCODE_FIELD_I[10:0];
  wire [10:0] op_z = ALU_OPCODE_FIELD_I[32:22];
  wire [10:0] op_w = ALU_OPCODE_FIELD_I[43:33];
  // nan never compares equal, so only ordinary values count as same
  wire x_same = SRC0_I[31:0] == SRC1_I[31:0] && SRC0_I[30:23] != `SAK_F_INF_EXP;
  wire go = GROUP_VALID_I && PIXEL_PROGRAM_I;
  idle_quiet_a:
    assert property (!GROUP_VALID_I |=> !RESULT_VALID_O && WRITE_MASK_O == 4'h0 && RESULT_O == 0)
    else $error("outputs written without a group");
  kill_eq_fires_a:
    assert property (go && op_x == `SAK_OP_FKILL_EQ && x_same
      |=> RESULT_O[31:0] == `SAK_F_ONE && WRITE_MASK_O[0] && PIXEL_KILLED_O)
    else $error("equal kill did not fire");
  kill_ne_quiet_a:
    assert property (go && op_x == `SAK_OP_FKILL_NE && x_same
      |=> RESULT_O[31:0] == `SAK_F_ZERO && WRITE_MASK_O[0])
    else $error("not-equal kill fired on equal values");
  no_kill_outside_a:
    assert property (!PIXEL_PROGRAM_I && !PIXEL_KILLED_O |=> !PIXEL_KILLED_O)
    else $error("kill outside a pixel program");
  kill_sticky_a:
    assert property (PIXEL_KILLED_O && !THREAD_START_I |=> PIXEL_KILLED_O)
    else $error("kill flag dropped inside a thread");
  live_held_a:
    assert property (!CLAUSE_END_I && !THREAD_START_I |=> $stable(PIXEL_LIVE_O))
    else $error("live state changed inside a clause");
  live_after_kill_a:
    assert property (CLAUSE_END_I && PIXEL_KILLED_O && !THREAD_START_I |=> !PIXEL_LIVE_O)
    else $error("killed pixel still live after clause");
  zw_route_a:
    assert property (GROUP_VALID_I && ALU_OPCODE_FIELD_I == {4{`SAK_OP_INTERP_PAIR_ZW}}
      |=> WRITE_MASK_O == 4'hf && RESULT_O[63:32] == RESULT_O[95:64]
      && RESULT_O[127:96] == RESULT_O[31:0])
    else $error("pair zw routing wrong");
  z_alone_a:
    assert property (GROUP_VALID_I && op_w == `SAK_OP_INTERP_SINGLE_Z && op_z != `SAK_OP_INTERP_SINGLE_Z
      |=> RESULT_VALID_O && GROUP_ERROR_O && WRITE_MASK_O == 4'h0)
    else $error("lone single z not refused");
endmodule
bind sak_alu_slice sak_alu_slice_asserts i_chk (.CLK_SYS_I(CLK_SYS_I), .RESET_N_I(RESET_N_I),
  .GROUP_VALID_I(GROUP_VALID_I), .ALU_OPCODE_FIELD_I(ALU_OPCODE_FIELD_I), .SRC0_I(SRC0_I),
  .SRC1_I(SRC1_I), .SRC2_I(SRC2_I), .PIXEL_PROGRAM_I(PIXEL_PROGRAM_I),
  .THREAD_START_I(THREAD_START_I), .CLAUSE_END_I(CLAUSE_END_I), .RESULT_O(RESULT_O),
  .WRITE_MASK_O(WRITE_MASK_O), .RESULT_VALID_O(RESULT_VALID_O), .GROUP_ERROR_O(GROUP_ERROR_O),
  .PIXEL_KILLED_O(PIXEL_KILLED_O), .PIXEL_LIVE_O(PIXEL_LIVE_O));

// File: sim/sak_seq_model.sv
// sequencer model: presents one group, holds it for one clock, then releases
// assumes the bench calls issue from one thread only
`timescale 1ns/10ps
module sak_seq_model (
  input wire clk_i,
  output logic valid_o,
  output logic [43:0] ops_o,
  output logic [127:0] src0_o,
  output logic [127:0] src1_o,
  output logic [127:0] src2_o,
  output logic pixel_o,
  output logic start_o,
  output logic end_o
);
  initial begin
    {valid_o, pixel_o, start_o, end_o} = 4'h0;
    {ops_o, src0_o, src1_o, src2_o} = 0;
  end
  task issue(input [43:0] ops, input [127:0] s0, s1, s2, input [3:0] vpse);
    @(posedge clk_i);
    #1;
    {ops_o, src0_o, src1_o, src2_o} = {ops, s0, s1, s2};
    {valid_o, pixel_o, start_o, end_o} = vpse;
    @(posedge clk_i);
    #1;
    // released operands must not look still valid
    {src0_o, src1_o, src2_o} = ~{src0_o, src1_o, src2_o};
    {valid_o, start_o, end_o} = 3'h0;
  endtask
endmodule

// File: sim/tb_top.sv
// top bench: interpolation routing and random kill compares
// assumes the sequencer model drives every group input
`timescale 1ns/10ps
`include "sak_defs.vh"
module tb_top;
  logic clk, rst_n;
  logic [31:0] seed;
  int fails, checks;
  wire v, pix, ts, ce, rv, err, kil, live;
  wire [43:0] ops;
  wire [127:0] s0, s1, s2, res;
  wire [3:0] mask;
  sak_seq_model i_seq (.clk_i(clk), .valid_o(v), .ops_o(ops), .src0_o(s0), .src1_o(s1),
    .src2_o(s2), .pixel_o(pix), .start_o(ts), .end_o(ce));
  sak_alu_slice i_dut (.CLK_SYS_I(clk), .RESET_N_I(rst_n), .GROUP_VALID_I(v),
    .ALU_OPCODE_FIELD_I(ops), .SRC0_I(s0), .SRC1_I(s1), .SRC2_I(s2), .PIXEL_PROGRAM_I(pix),
    .THREAD_START_I(ts), .CLAUSE_END_I(ce), .RESULT_O(res), .WRITE_MASK_O(mask),
    .RESULT_VALID_O(rv), .GROUP_ERROR_O(err), .PIXEL_KILLED_O(kil), .PIXEL_LIVE_O(live));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task stop_test;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input string what, input [127:0] exp, input [127:0] got);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h0);
  endfunction
  // float order via sign-magnitude to unsigned key; +0 and -0 are equal
  function hit(input [10:0] op, input [31:0] a, input [31:0] b);
    logic [31:0] ka, kb;
    logic fe;
    ka = a[31] ? ~a : {1'b1, a[30:0]};
    kb = b[31] ? ~b : {1'b1, b[30:0]};
    fe = a == b || (a[30:0] == 0 && b[30:0] == 0);
    case (op)
      `SAK_OP_FKILL_EQ: hit = fe;
      `SAK_OP_FKILL_GT: hit = ka > kb && !fe;
      `SAK_OP_FKILL_GE: hit = ka >= kb || fe;
      `SAK_OP_FKILL_NE: hit = !fe;
      `SAK_OP_UKILL_GT: hit = a > b;
      `SAK_OP_SKILL_EQ: hit = a == b;
      `SAK_OP_SKILL_GT: hit = $signed(a) > $signed(b);
      default: hit = a >= b;
    endcase
  endfunction
  task grp(input string what, input [43:0] o, input [127:0] x0, x1, x2, er, input [5:0] em);
    i_seq.issue(o, x0, x1, x2, 4'h8);
    chk(what, er, res);
    chk(what, em, {rv, err, mask});
  endtask
  task kill_try(input [10:0] op, input [31:0] a, input [31:0] b, input [3:0] vpse);
    logic h;
    h = hit(op, a, b) && vpse[2];
    i_seq.issue(0, 0, 0, 0, 4'h2);
    i_seq.issue({33'h0, op}, {96'h0, a}, {96'h0, b}, 0, vpse);
    chk("kill result", h ? `SAK_F_ONE : `SAK_F_ZERO, res[31:0]);
    chk("kill flags", {h, !h || !vpse[0], 3'h0, vpse[2]}, {kil, live, mask});
  endtask
  initial begin
    logic [31:0] a, b;
    logic [10:0] kops [9];
    fails = 0;
    checks = 0;
    rst_n = 1'b0;
    seed = 32'h000113d0;
    kops = '{`SAK_OP_FKILL_EQ, `SAK_OP_FKILL_GT, `SAK_OP_FKILL_GE, `SAK_OP_FKILL_NE,
      `SAK_OP_UKILL_GT, `SAK_OP_UKILL_GE, `SAK_OP_SKILL_EQ, `SAK_OP_SKILL_GT, `SAK_OP_IKILL_GE};
    repeat (6) @(posedge clk);
    #1 rst_n = 1'b1;
    grp("pair zw", {4{`SAK_OP_INTERP_PAIR_ZW}}, {32'h40000000, 32'h40000000, 32'h3f800000,
      32'h40000000}, {32'h3f800000, 32'h40000000, 32'h40000000, 32'h3f800000},
      {32'h3f800000, 32'h0, 32'h3f800000, 32'h0}, {32'h40a00000, {2{32'h40e00000}},
      32'h40a00000}, 6'h2f);
    grp("pair xy", {4{`SAK_OP_INTERP_PAIR_XY}}, {32'h40000000, 32'h40000000, 32'h3f800000,
      32'h40000000}, {32'h3f800000, 32'h40000000, 32'h40000000, 32'h3f800000},
      {32'h3f800000, 32'h0, 32'h3f800000, 32'h0}, {32'h40400000, {2{32'h40e00000}},
      32'h40a00000}, 6'h2f);
    grp("single z", {{2{`SAK_OP_INTERP_SINGLE_Z}}, 22'h0}, {64'h3f800001bf800002, 64'h0},
      {64'h3f8000013f800000, 64'h0}, 0, {64'h3f80000228800000, 64'h0}, 6'h2c);
    grp("lone z", {`SAK_OP_INTERP_SINGLE_Z, 33'h0}, 0, 0, 0, 0, 6'h30);
    $display("test interpolation done");
    kill_try(`SAK_OP_FKILL_EQ, 32'h0, 32'h80000000, 4'hd);
    kill_try(`SAK_OP_FKILL_NE, 32'h0, 32'h80000000, 4'hd);
    kill_try(`SAK_OP_FKILL_EQ, 32'h5, 32'h5, 4'h9);
    kill_try(`SAK_OP_FKILL_EQ, 32'h5, 32'h5, 4'hc);
    i_seq.issue(`SAK_OP_FKILL_EQ, 32'h5, 32'h6, 0, 4'hd);
    chk("sticky kill", 4'hb, {kil, live, rv, mask[0]});
    $display("test kill corners done");
    foreach (kops[k]) repeat (6) begin
      seed = lfsr(seed);
      a = seed;
      seed = lfsr(seed);
      b = seed[1] ? a : seed;
      if (kops[k] < 11'h040) begin
        a[30:29] = 2'b01;
        b[30:29] = 2'b01;
      end
      kill_try(kops[k], a, b, 4'hd);
    end
    $display("test random kill done");
    stop_test;
  end
  initial begin
    #100000;
    fails++;
    stop_test;
  end
endmodule
